// ===== mcs_pkg.sv
/*
  mcs_pkg: constants, field layouts and types shared by the meter control block.
  assumes a 200 MHz system clock and a 12-bit apb byte address.
*/
package mcs_pkg;
  // clock and debounce timing
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned CLK_HZ       = CLK_MHZ * 1_000_000;
  localparam int unsigned DEBOUNCE_US  = 10_000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;

  localparam int RDG_W  = 24;
  localparam int N_CTL  = 8;
  localparam int N_SP   = 4;
  localparam int ADDR_W = 12;
  localparam int LOCK_W = 5;
  localparam int DIV_W  = 20;

  // position of each control pin in the pin vector
  localparam int IN_TARE   = 0;
  localparam int IN_PEAK   = 1;
  localparam int IN_VALLEY = 2;
  localparam int IN_XRST   = 3;
  localparam int IN_HOLD   = 4;
  localparam int IN_LOCK   = 5;
  localparam int IN_PRINT  = 6;
  localparam int IN_MENU   = 7;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_SERFMT = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_LOCK   = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_DISP   = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_PEAK   = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_VALLEY = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_TARE   = 12'h01c;

  typedef enum logic [2:0] {
    BAUD_300 = 3'h0, BAUD_600 = 3'h1, BAUD_1200 = 3'h2, BAUD_2400 = 3'h3,
    BAUD_4800 = 3'h4, BAUD_9600 = 3'h5, BAUD_19200 = 3'h6
  } mcs_baud_t;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2
  } mcs_parity_t;

  typedef enum logic {MODE_RUN = 1'b0, MODE_SETUP = 1'b1} mcs_mode_t;

  // control register, bit 0 is reset_scope_select
  typedef struct packed {
    logic alarm_latch_mode;
    logic s2_swap;
    logic s1_swap;
    logic four_relay;
    logic relay2_alt;
    logic relay1_alt;
    logic alarm_latch_reset_enable;
    logic print_enable;
    logic reset_scope_select;
  } mcs_ctrl_t;
  localparam int        CTRL_W   = $bits(mcs_ctrl_t);
  localparam mcs_ctrl_t CTRL_RST = 9'h000;

  typedef struct packed {
    logic [7:0]  address;
    logic        stop_bit_select;
    mcs_parity_t parity_select;
    mcs_baud_t   baud;
  } mcs_sercfg_t;
  localparam int          SERCFG_W   = $bits(mcs_sercfg_t);
  localparam logic [7:0]  ADDR_DEF   = 8'h01;
  localparam logic [7:0]  ADDR_MAX   = 8'hc7;
  localparam mcs_sercfg_t SERCFG_RST = {ADDR_DEF, 1'b0, PAR_NONE, BAUD_9600};
  localparam logic [LOCK_W-1:0] LOCK_RST = 5'h1f;

  // clock cycles per serial bit
  function automatic logic [DIV_W-1:0] baud_div(input mcs_baud_t b);
    case (b)
      BAUD_300:   baud_div = DIV_W'(CLK_HZ / 300);
      BAUD_600:   baud_div = DIV_W'(CLK_HZ / 600);
      BAUD_1200:  baud_div = DIV_W'(CLK_HZ / 1200);
      BAUD_2400:  baud_div = DIV_W'(CLK_HZ / 2400);
      BAUD_4800:  baud_div = DIV_W'(CLK_HZ / 4800);
      BAUD_19200: baud_div = DIV_W'(CLK_HZ / 19200);
      default:    baud_div = DIV_W'(CLK_HZ / 9600);
    endcase
  endfunction : baud_div
endpackage : mcs_pkg

// ===== mcs_debounce.sv
/*
  mcs_debounce: two-flop synchroniser and debouncer for one active-low pin.
  assumes the pin is asynchronous; open (high) reads as deasserted.
*/
`timescale 1ns/1ps
`default_nettype none
module mcs_debounce #(
  parameter int unsigned CNT = mcs_pkg::DEBOUNCE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin_n,
  output logic      level,
  output logic      rise
);
  import mcs_pkg::*;
  localparam int CW = $clog2(CNT + 1);

  if (CNT < 1) begin : g_bad_cnt
    $error("debounce count must be at least one");
  end

  logic          meta_q, sync_q, level_q, rise_q;
  logic [CW-1:0] cnt_q;
  wire           done = (cnt_q == CW'(CNT - 1));

  // level only changes after the synced pin has differed for CNT cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      cnt_q   <= '0;
    end else if (ce) begin
      meta_q <= ~pin_n;  // ground means asserted
      sync_q <= meta_q;
      rise_q <= done && sync_q && !level_q;
      if (sync_q == level_q) cnt_q <= '0;
      else if (done) begin
        level_q <= sync_q;
        cnt_q   <= '0;
      end else cnt_q <= cnt_q + CW'(1);
    end
  end

  assign level = level_q;
  assign rise  = rise_q;
endmodule : mcs_debounce
`default_nettype wire

// ===== mcs_serfmt.sv
/*
  mcs_serfmt: serial format settings, communication lock bits and bit tick.
  assumes write strobes come from the apb decode in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module mcs_serfmt (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      lockout,
  input  wire logic                      fmt_wr,
  input  wire logic                      lock_wr,
  input  wire mcs_pkg::mcs_sercfg_t      fmt_wdata,
  input  wire logic [mcs_pkg::LOCK_W-1:0] lock_wdata,
  output logic                           fmt_ok,
  output mcs_pkg::mcs_sercfg_t           cfg,
  output logic [mcs_pkg::LOCK_W-1:0]     lock,
  output logic                           baud_tick
);
  import mcs_pkg::*;

  mcs_sercfg_t       cfg_q;
  logic [LOCK_W-1:0] lock_q;
  logic [DIV_W-1:0]  cnt_q;
  logic              tick_q;

  // a format write is only legal with every comm lock bit cleared
  wire legal = (fmt_wdata.baud <= BAUD_19200) && (fmt_wdata.parity_select <= PAR_EVEN)
            && (fmt_wdata.address != 8'h00) && (fmt_wdata.address <= ADDR_MAX);
  assign fmt_ok = !lockout && (lock_q == '0) && legal;  // RULE19 RULE7
  wire [DIV_W-1:0] div = baud_div(cfg_q.baud);  // RULE15

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q  <= SERCFG_RST;
      lock_q <= LOCK_RST;
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (fmt_wr && fmt_ok) cfg_q <= fmt_wdata;  // RULE16 RULE17 RULE18
      if (lock_wr && !lockout) lock_q <= lock_wdata;
      tick_q <= (cnt_q >= div - DIV_W'(1));
      cnt_q  <= (cnt_q >= div - DIV_W'(1)) ? '0 : cnt_q + DIV_W'(1);
    end
  end

  assign cfg       = cfg_q;
  assign lock      = lock_q;
  assign baud_tick = tick_q;
endmodule : mcs_serfmt
`default_nettype wire

// ===== mcs_top.sv
/*
  mcs_top: control logic of a panel meter - rear control inputs, display
  source and hold, peak/valley, setpoint and relay outputs, serial format.
  assumes readings and setpoint trips arrive from logic on clk; control pins
  and aux rx are asynchronous; apb master on clk.
*/
// How it works
// (RULE1) a tare closure stores the live reading so the net reading becomes zero
// (RULE2) while peak select is held the display shows stored highest reading, flashing
// (RULE3) while valley select is held the display shows stored lowest reading, flashing
// (RULE4) external reset: scope 0 gives hard reset, scope 1 clears peak/valley only
// (RULE5) while hold is grounded the displayed value stays frozen
// (RULE6) during hold, sampling, setpoints and peak/valley keep updating
// (RULE7) lockout rejects configuration writes and any nonvolatile store
// (RULE8) lockout in run mode ignores the menu button, no setup entry
// (RULE9) print input with print enable starts a serial printout
// (RULE10) print input with alarm latch reset enable clears latched alarms
// (RULE11) aux rx/tx pins carry rs-232 framing at logic levels
// (RULE12) four open-collector setpoint outputs, the last two being the alarms
// (RULE13) dual board: relay one from setpoint three or one, two from four or two
// (RULE14) four-relay board: two swap groups exchange setpoints one/three and two/four
// (RULE15) baud selectable from 300 to 19200, default 9600
// (RULE16) parity code 0 none, 1 odd, 2 even
// (RULE17) stop-bit code 0 one stop bit, 1 two stop bits
// (RULE18) each device has a unique address, default 001, up to 199
// (RULE19) serial format changes only when all five comm lock bits are zero
// (RULE20) each control pin is synchronised and debounced, ground means asserted
`timescale 1ns/1ps
`default_nettype none
module mcs_top #(
  parameter int unsigned DEBOUNCE = mcs_pkg::DEBOUNCE_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire logic [mcs_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [mcs_pkg::N_CTL-1:0]   ctl_pin_n,
  input  wire logic [mcs_pkg::RDG_W-1:0]   reading_in,
  input  wire logic                        reading_vld,
  input  wire logic [mcs_pkg::N_SP-1:0]    sp_trip,
  output logic [mcs_pkg::N_SP-1:0]         sp_pin_o,
  output logic [mcs_pkg::N_SP-1:0]         sp_pin_oe,
  output logic [mcs_pkg::N_SP-1:0]         relay_o,
  output logic [mcs_pkg::RDG_W-1:0]        display_o,
  output logic                             display_flash_o,
  output logic                             hard_reset_o,
  output logic                             setup_mode_o,
  output logic                             print_start_o,
  output logic                             nv_store_o,
  output mcs_pkg::mcs_sercfg_t             ser_cfg_o,
  output logic                             baud_tick_o,
  input  wire logic                        aux_rx_pin,
  output logic                             aux_rx_o,
  input  wire logic                        aux_tx_i,
  output logic                             aux_tx_pin
);
  import mcs_pkg::*;

  if (DEBOUNCE < 1) begin : g_bad_deb
    $error("DEBOUNCE must be at least one cycle");
  end

  // reset release through two flops
  logic rst_m_q, rst_s_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_n <= 1'b0;
    end else if (ce) begin
      rst_m_q <= 1'b1;
      rst_s_n <= rst_m_q;
    end
  end

  // control pins, one debouncer each
  logic [N_CTL-1:0] lvl, ev;
  for (genvar i = 0; i < N_CTL; i++) begin : g_pin
    mcs_debounce #(.CNT(DEBOUNCE)) u_deb (
      .clk   (clk),
      .rst_n (rst_s_n),
      .ce    (ce),
      .pin_n (ctl_pin_n[i]),
      .level (lvl[i]),  // RULE20
      .rise  (ev[i])
    );
  end

  wire lockout = lvl[IN_LOCK];

  // state
  mcs_ctrl_t              ctrl_q;
  mcs_mode_t              mode_q;
  logic [RDG_W-1:0]       live_q, tare_q, peak_q, valley_q, disp_q;
  logic                   samp_q, flash_q, hard_q, print_q, nv_q, ack_q;
  logic [1:0]             alarm_q;
  logic [N_SP-1:0]        sp_q, relay_q;
  logic [31:0]            rdata_q;
  logic                   rx_m_q, rx_s_q, tx_q;

  // apb decode: access phase waits one cycle so read data comes from a flop
  wire        acc      = psel && penable;
  wire        fire     = acc && ack_q;
  wire        wr_fire  = fire && pwrite;
  wire        hit_ctrl = (paddr == OFF_CTRL);
  wire        hit_fmt  = (paddr == OFF_SERFMT);
  wire        hit_lock = (paddr == OFF_LOCK);
  wire        hit_ro   = (paddr == OFF_STATUS) || (paddr == OFF_DISP) ||
                         (paddr == OFF_PEAK) || (paddr == OFF_VALLEY) ||
                         (paddr == OFF_TARE);
  wire        mapped   = hit_ctrl || hit_fmt || hit_lock || hit_ro;
  logic [31:0] wmask;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{pstrb[b]}};
  end
  logic [LOCK_W-1:0] lock_bits;
  logic              fmt_ok;
  wire [31:0] m_ctrl = (32'(ctrl_q) & ~wmask) | (pwdata & wmask);
  wire [31:0] m_fmt  = (32'(ser_cfg_o) & ~wmask) | (pwdata & wmask);
  wire [31:0] m_lock = (32'(lock_bits) & ~wmask) | (pwdata & wmask);

  // a refused write answers with pslverr and changes nothing
  wire rejected = (hit_ctrl && lockout) || (hit_lock && lockout) ||  // RULE7
                  (hit_fmt && !fmt_ok) || hit_ro;
  wire cfg_wr   = wr_fire && (hit_ctrl || hit_fmt || hit_lock) && !rejected;
  assign pready  = acc && ack_q;
  assign pslverr = pready && (!mapped || (pwrite && rejected));
  assign prdata  = rdata_q;

  mcs_serfmt u_ser (
    .clk        (clk),
    .rst_n      (rst_s_n),
    .ce         (ce),
    .lockout    (lockout),
    .fmt_wr     (wr_fire && hit_fmt),
    .lock_wr    (wr_fire && hit_lock),
    .fmt_wdata  (mcs_sercfg_t'(m_fmt[SERCFG_W-1:0])),
    .lock_wdata (m_lock[LOCK_W-1:0]),
    .fmt_ok     (fmt_ok),
    .cfg        (ser_cfg_o),
    .lock       (lock_bits),
    .baud_tick  (baud_tick_o)
  );

  // reading path: net = live - tare, peak/valley track the net value
  wire [RDG_W-1:0] net     = live_q - tare_q;
  wire             hard_ev = ev[IN_XRST] && !ctrl_q.reset_scope_select;  // RULE4
  wire             pv_clr  = ev[IN_XRST];  // RULE4
  wire             prt_ev  = ev[IN_PRINT];
  wire             alm_clr = (prt_ev && ctrl_q.alarm_latch_reset_enable) || hard_ev;  // RULE10
  wire             up_pk   = samp_q && ($signed(net) > $signed(peak_q));
  wire             up_vl   = samp_q && ($signed(net) < $signed(valley_q));

  // display source: peak wins over valley, both over net
  wire [RDG_W-1:0] src = lvl[IN_PEAK]   ? peak_q :  // RULE2
                         lvl[IN_VALLEY] ? valley_q : net;  // RULE3
  wire [RDG_W-1:0] disp_d = lvl[IN_HOLD] ? disp_q : src;  // RULE5

  // setpoint lines: alarms may latch; set beats clear in the same cycle
  wire [1:0]      alarm_d = (alarm_q & ~{2{alm_clr}}) | sp_trip[3:2];  // RULE10
  wire [N_SP-1:0] sp_d    = {ctrl_q.alarm_latch_mode ? alarm_d : sp_trip[3:2],
                             sp_trip[1:0]};  // RULE12

  // relay routing for dual and four-relay boards
  wire [N_SP-1:0] rel_dual = {2'b00,
                              ctrl_q.relay2_alt ? sp_q[1] : sp_q[3],
                              ctrl_q.relay1_alt ? sp_q[0] : sp_q[2]};  // RULE13
  wire [N_SP-1:0] rel_four = {ctrl_q.s2_swap ? sp_q[1] : sp_q[3],
                              ctrl_q.s1_swap ? sp_q[0] : sp_q[2],
                              ctrl_q.s2_swap ? sp_q[3] : sp_q[1],
                              ctrl_q.s1_swap ? sp_q[2] : sp_q[0]};  // RULE14
  wire [N_SP-1:0] relay_d  = ctrl_q.four_relay ? rel_four : rel_dual;

  // menu button enters or leaves setup; lockout blocks entry from run
  wire menu_in = ev[IN_MENU] && (mode_q == MODE_RUN) && !lockout;  // RULE8
  wire menu_out = ev[IN_MENU] && (mode_q == MODE_SETUP);

  // read mux
  wire [31:0] status = 32'({mode_q, flash_q, alarm_q, lvl});
  logic [31:0] rd_d;
  always_comb begin
    case (paddr)
      OFF_CTRL:   rd_d = 32'(ctrl_q);
      OFF_SERFMT: rd_d = 32'(ser_cfg_o);
      OFF_LOCK:   rd_d = 32'(lock_bits);
      OFF_STATUS: rd_d = status;
      OFF_DISP:   rd_d = 32'(disp_q);
      OFF_PEAK:   rd_d = 32'(peak_q);
      OFF_VALLEY: rd_d = 32'(valley_q);
      OFF_TARE:   rd_d = 32'(tare_q);
      default:    rd_d = 32'h0000_0000;
    endcase
  end

  // bus handshake and software control register
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_q  <= CTRL_RST;
      nv_q    <= 1'b0;
    end else if (ce) begin
      ack_q <= acc && !ack_q;
      if (acc && !ack_q) rdata_q <= rd_d;
      if (wr_fire && hit_ctrl && !lockout) ctrl_q <= mcs_ctrl_t'(m_ctrl[CTRL_W-1:0]);
      nv_q <= cfg_wr && !lockout;  // RULE7
    end
  end

  // sampling, tare and peak/valley continue regardless of hold
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      live_q   <= '0;
      samp_q   <= 1'b0;
      tare_q   <= '0;
      peak_q   <= '0;
      valley_q <= '0;
    end else if (ce) begin
      samp_q <= reading_vld;
      if (reading_vld) live_q <= reading_in;  // RULE6
      if (hard_ev) tare_q <= '0;
      else if (ev[IN_TARE]) tare_q <= live_q;  // RULE1
      if (pv_clr) begin
        peak_q   <= net;
        valley_q <= net;
      end else begin
        if (up_pk) peak_q <= net;  // RULE6
        if (up_vl) valley_q <= net;
      end
    end
  end

  // display, events and outputs
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      disp_q  <= '0;
      flash_q <= 1'b0;
      hard_q  <= 1'b0;
      print_q <= 1'b0;
      alarm_q <= 2'b00;
      sp_q    <= '0;
      relay_q <= '0;
      mode_q  <= MODE_RUN;
    end else if (ce) begin
      disp_q  <= disp_d;
      flash_q <= lvl[IN_PEAK] || lvl[IN_VALLEY];  // RULE2 RULE3
      hard_q  <= hard_ev;
      print_q <= prt_ev && ctrl_q.print_enable;  // RULE9
      alarm_q <= alarm_d;
      sp_q    <= sp_d;
      relay_q <= relay_d;
      case (mode_q)
        MODE_RUN:   if (menu_in) mode_q <= MODE_SETUP;
        MODE_SETUP: if (menu_out || hard_ev) mode_q <= MODE_RUN;
        default:    mode_q <= MODE_RUN;
      endcase
    end
  end

  // aux port: rx through two flops, tx retimed, idle mark after reset
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      tx_q   <= 1'b1;
    end else if (ce) begin
      rx_m_q <= aux_rx_pin;  // RULE11
      rx_s_q <= rx_m_q;
      tx_q   <= aux_tx_i;  // RULE11
    end
  end

  assign aux_rx_o        = rx_s_q;
  assign aux_tx_pin      = tx_q;
  assign sp_pin_o        = '0;  // open collector: only ever pulls low
  assign sp_pin_oe       = sp_q;  // RULE12
  assign relay_o         = relay_q;
  assign display_o       = disp_q;
  assign display_flash_o = flash_q;
  assign hard_reset_o    = hard_q;
  assign setup_mode_o    = (mode_q == MODE_SETUP);
  assign print_start_o   = print_q;
  assign nv_store_o      = nv_q;

  // checks
  chk_tare_zero: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE1
    ev[IN_TARE] && !hard_ev && ce |=> tare_q == $past(live_q))
    else $error("tare did not capture live reading");
  chk_peak_shown: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE2
    lvl[IN_PEAK] && !lvl[IN_HOLD] && ce |=> disp_q == $past(peak_q) && flash_q)
    else $error("peak not displayed flashing");
  chk_valley_shown: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE3
    lvl[IN_VALLEY] && !lvl[IN_PEAK] && !lvl[IN_HOLD] && ce
    |=> disp_q == $past(valley_q) && flash_q)
    else $error("valley not displayed flashing");
  chk_hard_reset: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE4
    ev[IN_XRST] && ce |=> hard_reset_o == !$past(ctrl_q.reset_scope_select)
    && peak_q == $past(net) && valley_q == $past(net))
    else $error("external reset scope wrong");
  chk_hold_freeze: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE5
    lvl[IN_HOLD] && ce |=> $stable(disp_q))
    else $error("display moved during hold");
  chk_hold_sample: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE6
    lvl[IN_HOLD] && reading_vld && ce |=> live_q == $past(reading_in))
    else $error("sampling stopped during hold");
  chk_lock_store: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE7
    lockout && ce |=> !nv_store_o)
    else $error("store during lockout");
  chk_lock_menu: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE8
    lockout && mode_q == MODE_RUN && ce |=> mode_q == MODE_RUN)
    else $error("setup entered under lockout");
  chk_print_start: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE9
    prt_ev && ctrl_q.print_enable && ce |=> print_start_o ##1 !print_start_o)
    else $error("print start missing");
  chk_alarm_clear: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE10
    prt_ev && ctrl_q.alarm_latch_reset_enable && ce |=> alarm_q == $past(sp_trip[3:2]))
    else $error("latched alarms not cleared");
  chk_relay_dual: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE13
    !ctrl_q.four_relay && ce |=> relay_o[0] == $past(ctrl_q.relay1_alt ? sp_q[0] : sp_q[2]))
    else $error("dual relay routing wrong");
  chk_relay_four: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE14
    ctrl_q.four_relay && ce |=> relay_o[2] == $past(ctrl_q.s1_swap ? sp_q[0] : sp_q[2]))
    else $error("four relay routing wrong");
  chk_parity_legal: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE16
    ser_cfg_o.parity_select != 2'h3 && ser_cfg_o.address != 8'h00)
    else $error("illegal serial format held");
  chk_fmt_locked: assert property (@(posedge clk) disable iff (!rst_s_n)  // RULE19
    wr_fire && hit_fmt && lock_bits != '0 |=> $stable(ser_cfg_o))
    else $error("format changed while locked");
endmodule : mcs_top
`default_nettype wire

// ===== mcs_host_model.sv
/* mcs_host_model: rear switches and serial host facing the meter.
   assumes open pins float high through pull-ups. */
`timescale 1ns/1ps
`default_nettype none
module mcs_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] press,
  input  wire logic       tx_pin,
  output logic      [7:0] pin_n,
  output logic            rx_pin
);
  // a closure grounds the pin, an open switch reads high
  assign pin_n = ~press;
  // host echoes the aux line, idle high as rs-232 framing expects
  always_ff @(posedge clk) rx_pin <= tx_pin;
endmodule : mcs_host_model
`default_nettype wire

// ===== mcs_top_test.sv
/* mcs_top_test: directed scenarios for the meter control block.
   assumes DEBOUNCE of 4 and apb answering after one wait state. */
`timescale 1ns/1ps
`default_nettype none
module mcs_top_test;
  import mcs_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, vld = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, hrst, flash, setup, aux_rx, tx_pin, seen;
  logic        tx = 1, rxo, prt, nv;
  logic [7:0]  press = '0, pin_n;
  logic [23:0] rdg = '0, disp;
  logic [3:0]  trip = '0, oe, relay;
  mcs_sercfg_t cfg;
  int          num_errors = 0, total_checks = 0, cyc = 0;

  mcs_top #(.DEBOUNCE(4)) mcs_top_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl_pin_n(pin_n),
    .reading_in(rdg), .reading_vld(vld), .sp_trip(trip), .sp_pin_o(), .sp_pin_oe(oe),
    .relay_o(relay), .display_o(disp), .display_flash_o(flash), .hard_reset_o(hrst),
    .setup_mode_o(setup), .print_start_o(prt), .nv_store_o(nv), .ser_cfg_o(cfg),
    .baud_tick_o(), .aux_rx_pin(aux_rx), .aux_rx_o(rxo), .aux_tx_i(tx),
    .aux_tx_pin(tx_pin));
  mcs_host_model mcs_host_model_inst (.clk(clk), .press(press), .tx_pin(tx_pin),
    .pin_n(pin_n), .rx_pin(aux_rx));

  initial forever #2.5 clk = ~clk;

  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; pready and data taken at the rising edge, one idle edge after
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb

  task automatic feed(input logic [23:0] v);
    @(posedge clk);
    rdg <= v;
    vld <= 1;
    @(posedge clk);
    vld <= 0;
  endtask : feed

  task automatic pins(input logic [7:0] p);
    @(posedge clk);
    press <= p;
    repeat (12) @(posedge clk);
  endtask : pins

  // format defaults, lock gating, every baud and parity code, bad fields
  task automatic t_serial;
    apb(0, OFF_SERFMT, 0);
    chk(rd, 32'h045);
    apb(0, OFF_LOCK, 0);
    chk(rd, 32'h1f);
    apb(1, OFF_SERFMT, 32'h31f6);
    chk(32'(err), 1);
    apb(1, OFF_LOCK, 0);
    apb(1, OFF_SERFMT, 32'h31f6);
    chk(32'(cfg), 32'h31f6);
    for (int i = 0; i < 7; i++) begin
      apb(1, OFF_SERFMT, 32'h40 | 32'((i % 3) << 3) | 32'(i));
      chk(32'(cfg), 32'h40 | 32'((i % 3) << 3) | 32'(i));
    end
    apb(1, OFF_SERFMT, 32'h0d);
    chk(32'(err), 1);
    apb(1, OFF_SERFMT, 32'h58);
    chk(32'(err), 1);
    apb(0, 12'h020, 0);
    chk(32'(err), 1);
  endtask : t_serial

  // dual board default and alternate routing, then one four-relay swap
  task automatic t_relay;
    trip <= 4'b0100;
    repeat (3) @(posedge clk);
    chk(32'(oe), 32'h4);
    chk(32'(relay), 32'h1);
    apb(1, OFF_CTRL, 32'h18);
    trip <= 4'b0010;
    repeat (3) @(posedge clk);
    chk(32'(relay), 32'h2);
    apb(1, OFF_CTRL, 32'h60);
    trip <= 4'b0001;
    repeat (3) @(posedge clk);
    chk(32'(relay), 32'h4);
    trip <= 4'b0000;
  endtask : t_relay

  // lockout refuses a config write and a menu press in run mode
  task automatic t_lockout;
    pins(8'h20);
    apb(1, OFF_CTRL, 0);
    chk(32'(err), 1);
    pins(8'ha0);
    chk(32'(setup), 0);
    pins(8'h00);
    pins(8'h80);
    chk(32'(setup), 1);
    pins(8'h00);
  endtask : t_lockout

  // peak/valley selection, then hold freezing display while peak still tracks
  task automatic t_display;
    feed(24'hfffffe);
    feed(24'h9);
    feed(24'h3);
    pins(8'h02);
    chk(32'(disp), 32'h9);
    chk(32'(flash), 1);
    pins(8'h04);
    chk(32'(disp), 32'hfffffe);
    pins(8'h00);
    pins(8'h10);
    feed(24'h14);
    chk(32'(disp), 32'h3);
    apb(0, OFF_PEAK, 0);
    chk(rd, 32'h14);
    pins(8'h00);
  endtask : t_display

  // external reset: scope 0 gives hard reset pulse, scope 1 reloads peak/valley with no hard reset
  task automatic t_xreset;
    seen = 0;
    press <= 8'h08;
    repeat (20) @(negedge clk) seen |= hrst;
    chk(32'(seen), 1);
    pins(8'h00);
    apb(1, OFF_CTRL, 32'h1);
    feed(24'h32);
    feed(24'h1e);
    seen = 0;
    press <= 8'h08;
    repeat (20) @(negedge clk) seen |= hrst;
    chk(32'(seen), 0);
    apb(0, OFF_PEAK, 0);
    chk(rd, 32'h1e);
    pins(8'h00);
  endtask : t_xreset

  // tare zeroes net, print pulses and clears a latched alarm, aux line echoes
  task automatic t_tare_print;
    pins(8'h01);
    apb(0, OFF_DISP, 0);
    chk(rd, 0);
    apb(1, OFF_CTRL, 32'h107);
    chk(32'(nv), 1);
    trip <= 4'b1000;
    repeat (2) @(posedge clk);
    trip <= 4'b0000;
    repeat (3) @(posedge clk);
    chk(32'(oe), 32'h8);
    seen = 0;
    press <= 8'h40;
    repeat (20) @(negedge clk) seen |= prt;
    chk(32'(seen), 1);
    chk(32'(oe), 0);
    pins(8'h00);
    tx <= 0;
    repeat (6) @(posedge clk);
    chk(32'(rxo), 0);
    tx <= 1;
  endtask : t_tare_print

  // the run is well under a thousand cycles; 20000 only trips on a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    t_serial();
    t_relay();
    t_lockout();
    t_display();
    t_xreset();
    t_tare_print();
    summarize();
  end
endmodule : mcs_top_test
`default_nettype wire
